// *** logic/pport_fwd_mask.sv ***
// Top: applies private VLAN isolation to forwarding lookups
`timescale 1ns/100ps
module pport_fwd_mask (
  input  wire logic                   clk_sys_i,
  input  wire logic                   rstn_i,
  input  wire pport_pkg::lookup_s     lookup_i,
  input  wire pport_pkg::cfg_s        cfg_i,
  output pport_pkg::result_s          result_o,
  output pport_pkg::pmask_t           iso_ports_o,
  output pport_pkg::pmask_t           prom_ports_o
);
  // Lookup and write captures feed only the checks below
  typedef struct packed {
    pport_pkg::result_s res;
    pport_pkg::pmask_t  iso_rd;
    pport_pkg::pmask_t  prom_rd;
    logic               lk_seen;
    logic               lk_src_iso;
    logic               lk_src_ok;
    pport_pkg::pmask_t  lk_vmask;
    pport_pkg::pmask_t  lk_iso;
    logic               wr_seen;
    pport_pkg::pmask_t  wr_mask;
    pport_pkg::pmask_t  wr_data;
  } st_s;
  st_s st_r;
  st_s st_nxt;
  pport_pkg::pmask_t iso_w;

  // Ports beyond the last one count as promiscuous
  function automatic logic src_in_range(
    input logic [pport_pkg::PIDX_W-1:0] src
  );
    return src < pport_pkg::PIDX_W'(pport_pkg::NPORTS);
  endfunction : src_in_range

  function automatic logic src_is_iso(
    input logic [pport_pkg::PIDX_W-1:0] src,
    input pport_pkg::pmask_t            iso
  );
    logic hit;
    hit = 1'b0;
    if (src_in_range(src)) begin
      hit = iso[src];
    end
    return hit;
  endfunction : src_is_iso

  function automatic pport_pkg::pmask_t prom_of(
    input pport_pkg::pmask_t iso
  );
    return ~iso & pport_pkg::ALL_PORT;
  endfunction : prom_of

  function automatic pport_pkg::pmask_t apply_iso(
    input pport_pkg::pmask_t           vmask,
    input logic [pport_pkg::PIDX_W-1:0] src,
    input pport_pkg::pmask_t           iso
  );
    pport_pkg::pmask_t fwd;
    fwd = vmask;
    // Only ever narrows the VLAN mask
    if (src_is_iso(src, iso)) begin
      fwd = vmask & prom_of(iso); // [R1] [R2] [R6] [R9]
    end
    return fwd; // [R3] [R4] [R5]
  endfunction : apply_iso

  // Shared across all VLANs: no VLAN id reaches the store
  pport_iso_store u_store ( // [R7]
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .cfg_i     (cfg_i),
    .iso_o     (iso_w)
  );

  always_comb begin
    st_nxt = st_r;
    st_nxt.res.valid    = lookup_i.valid;
    st_nxt.res.fwd_mask = lookup_i.valid ?
      apply_iso(lookup_i.vlan_mask, lookup_i.src_port, iso_w) : '0;
    st_nxt.iso_rd  = iso_w; // [R10]
    st_nxt.prom_rd = prom_of(iso_w); // [R10]
    st_nxt.lk_seen    = lookup_i.valid;
    st_nxt.lk_src_iso = src_is_iso(lookup_i.src_port, iso_w);
    st_nxt.lk_src_ok  = src_in_range(lookup_i.src_port);
    st_nxt.lk_vmask   = lookup_i.vlan_mask;
    st_nxt.lk_iso     = iso_w;
    st_nxt.wr_seen    = cfg_i.wr;
    st_nxt.wr_mask    = cfg_i.wr_mask;
    st_nxt.wr_data    = cfg_i.wr_data;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      st_r.res        <= '0;
      st_r.iso_rd     <= pport_pkg::ISO_RST;
      st_r.prom_rd    <= pport_pkg::ALL_PORT; // [R8]
      st_r.lk_seen    <= 1'b0;
      st_r.lk_src_iso <= 1'b0;
      st_r.lk_src_ok  <= 1'b0;
      st_r.lk_vmask   <= '0;
      st_r.lk_iso     <= pport_pkg::ISO_RST;
      st_r.wr_seen    <= 1'b0;
      st_r.wr_mask    <= '0;
      st_r.wr_data    <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign result_o     = st_r.res;
  assign iso_ports_o  = st_r.iso_rd;
  assign prom_ports_o = st_r.prom_rd;

  a_fwd_subset: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    lookup_i.valid |=> (result_o.fwd_mask & ~$past(lookup_i.vlan_mask)) == '0) // [R9]
    else $error("forward mask wider than VLAN mask");
  a_iso_to_prom: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    lookup_i.valid && iso_w[lookup_i.src_port] |=>
      (result_o.fwd_mask & $past(iso_w)) == '0) // [R1]
    else $error("isolated ingress reached an isolated port");
  a_iso_exact: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    lookup_i.valid && iso_w[lookup_i.src_port] |=>
      result_o.fwd_mask == ($past(lookup_i.vlan_mask) & ~$past(iso_w))) // [R6]
    else $error("isolated ingress mask wrong");
  a_prom_pass: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    lookup_i.valid && !iso_w[lookup_i.src_port] |=>
      result_o.fwd_mask == $past(lookup_i.vlan_mask)) // [R5]
    else $error("promiscuous ingress mask altered");
  a_iso_rx_only: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    lookup_i.valid ##1 (result_o.fwd_mask & $past(iso_w)) != '0 |->
      !$past(iso_w[lookup_i.src_port])) // [R2]
    else $error("isolated port fed from isolated ingress");
  a_prom_rx_all: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    lookup_i.valid |=> (result_o.fwd_mask & ~$past(iso_w)) ==
      ($past(lookup_i.vlan_mask) & ~$past(iso_w))) // [R4]
    else $error("promiscuous port dropped");
  a_prom_tx_all: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    lookup_i.valid && !iso_w[lookup_i.src_port] |=>
      (result_o.fwd_mask & $past(iso_w)) == ($past(lookup_i.vlan_mask) & $past(iso_w))) // [R3]
    else $error("promiscuous ingress blocked to isolated");
  a_readback_pair: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (iso_ports_o ^ prom_ports_o) == pport_pkg::ALL_PORT ##1 iso_ports_o == $past(iso_w)) // [R10]
    else $error("readback sets inconsistent");
  a_reset_prom: assert property (@(posedge clk_sys_i) !rstn_i |=> prom_ports_o == pport_pkg::ALL_PORT) // [R8]
    else $error("ports not promiscuous after reset");
  a_idle_zero: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !lookup_i.valid |=> !result_o.valid && result_o.fwd_mask == '0) // [R9]
    else $error("result without lookup");

  // Checks against the captured lookup, so no sampled history is needed
  a_res_on_lookup: assert property ( // [R9]
    @(posedge clk_sys_i) disable iff (!rstn_i)
    st_r.lk_seen |->
      result_o.valid)
    else $error("lookup gave no result");

  a_res_no_lookup: assert property ( // [R9]
    @(posedge clk_sys_i) disable iff (!rstn_i)
    !st_r.lk_seen |->
      !result_o.valid)
    else $error("result appeared with no lookup");

  a_cap_iso_narrow: assert property ( // [R6]
    @(posedge clk_sys_i) disable iff (!rstn_i)
    st_r.lk_seen && st_r.lk_src_iso |->
      result_o.fwd_mask == (st_r.lk_vmask & ~st_r.lk_iso))
    else $error("isolated ingress not narrowed");

  a_cap_prom_pass: assert property ( // [R5]
    @(posedge clk_sys_i) disable iff (!rstn_i)
    st_r.lk_seen && !st_r.lk_src_iso |->
      result_o.fwd_mask == st_r.lk_vmask)
    else $error("promiscuous ingress changed");

  a_cap_subset: assert property ( // [R9]
    @(posedge clk_sys_i) disable iff (!rstn_i)
    st_r.lk_seen |->
      (result_o.fwd_mask & ~st_r.lk_vmask) == '0)
    else $error("result outside VLAN members");

  a_cap_iso_dest: assert property ( // [R1]
    @(posedge clk_sys_i) disable iff (!rstn_i)
    st_r.lk_seen && st_r.lk_src_iso |->
      (result_o.fwd_mask & st_r.lk_iso) == '0)
    else $error("isolated ingress reached isolated port");

  a_range_prom: assert property ( // [R5]
    @(posedge clk_sys_i) disable iff (!rstn_i)
    st_r.lk_seen && !st_r.lk_src_ok |->
      result_o.fwd_mask == st_r.lk_vmask)
    else $error("out of range ingress was masked");

  a_iso_rx_prom: assert property ( // [R2]
    @(posedge clk_sys_i) disable iff (!rstn_i)
    st_r.lk_seen && (result_o.fwd_mask & st_r.lk_iso) != '0 |->
      !st_r.lk_src_iso)
    else $error("isolated port got isolated traffic");

  a_prom_rx_keep: assert property ( // [R4]
    @(posedge clk_sys_i) disable iff (!rstn_i)
    st_r.lk_seen |->
      (result_o.fwd_mask & ~st_r.lk_iso) == (st_r.lk_vmask & ~st_r.lk_iso))
    else $error("promiscuous member was dropped");

  a_prom_tx_iso: assert property ( // [R3]
    @(posedge clk_sys_i) disable iff (!rstn_i)
    st_r.lk_seen && !st_r.lk_src_iso |->
      (result_o.fwd_mask & st_r.lk_iso) == (st_r.lk_vmask & st_r.lk_iso))
    else $error("promiscuous ingress kept from isolated");

  a_no_vlan_none: assert property ( // [R9]
    @(posedge clk_sys_i) disable iff (!rstn_i)
    st_r.lk_seen && st_r.lk_vmask == '0 |->
      result_o.fwd_mask == '0)
    else $error("result without VLAN members");

  a_all_prom_pass: assert property ( // [R5]
    @(posedge clk_sys_i) disable iff (!rstn_i)
    st_r.lk_seen && st_r.lk_iso == '0 |->
      result_o.fwd_mask == st_r.lk_vmask)
    else $error("mask narrowed with no isolated port");

  a_idle_mask: assert property ( // [R9]
    @(posedge clk_sys_i) disable iff (!rstn_i)
    !result_o.valid |->
      result_o.fwd_mask == '0)
    else $error("mask shown without result");

  // Write path: a lookup beside a write still sees the old setting
  a_wr_applied: assert property ( // [R11]
    @(posedge clk_sys_i) disable iff (!rstn_i)
    st_r.wr_seen |->
      (iso_w & st_r.wr_mask) == (st_r.wr_data & st_r.wr_mask))
    else $error("masked write lost");

  a_wr_keeps_rest: assert property ( // [R11]
    @(posedge clk_sys_i) disable iff (!rstn_i)
    st_r.wr_seen |->
      (iso_w & ~st_r.wr_mask) == (st_r.lk_iso & ~st_r.wr_mask))
    else $error("write touched unmasked ports");

  a_no_wr_hold: assert property ( // [R11]
    @(posedge clk_sys_i) disable iff (!rstn_i)
    !st_r.wr_seen |->
      iso_w == st_r.lk_iso)
    else $error("isolation changed without write");

  a_wr_to_rb: assert property ( // [R10]
    @(posedge clk_sys_i) disable iff (!rstn_i)
    st_r.wr_seen |=>
      (iso_ports_o & $past(st_r.wr_mask)) == ($past(st_r.wr_data) & $past(st_r.wr_mask)))
    else $error("isolated readback missed write");

  a_wr_rb_prom: assert property ( // [R10]
    @(posedge clk_sys_i) disable iff (!rstn_i)
    st_r.wr_seen |=>
      (prom_ports_o & $past(st_r.wr_mask)) == (~$past(st_r.wr_data) & $past(st_r.wr_mask)))
    else $error("promiscuous readback missed write");

  a_rb_iso_follow: assert property ( // [R10]
    @(posedge clk_sys_i) disable iff (!rstn_i)
    1'b1 |->
      iso_ports_o == st_r.lk_iso)
    else $error("isolated readback stale");

  a_rb_prom_inv: assert property ( // [R10]
    @(posedge clk_sys_i) disable iff (!rstn_i)
    1'b1 |->
      prom_ports_o == ~iso_ports_o)
    else $error("readback sets not complementary");

  a_rb_disjoint: assert property ( // [R10]
    @(posedge clk_sys_i) disable iff (!rstn_i)
    1'b1 |->
      (iso_ports_o & prom_ports_o) == '0)
    else $error("port in both readback sets");

  a_rb_cover: assert property ( // [R10]
    @(posedge clk_sys_i) disable iff (!rstn_i)
    1'b1 |->
      (iso_ports_o | prom_ports_o) == pport_pkg::ALL_PORT)
    else $error("port in neither readback set");

  // Reset checks carry no disable so they watch the reset cycles too
  a_rst_result: assert property ( // [R8]
    @(posedge clk_sys_i)
    !rstn_i |=>
      !result_o.valid && result_o.fwd_mask == '0)
    else $error("result not cleared by reset");

  a_rst_iso_rb: assert property ( // [R8]
    @(posedge clk_sys_i)
    !rstn_i |=>
      iso_ports_o == pport_pkg::ISO_RST)
    else $error("isolated readback not reset");

  a_rst_store: assert property ( // [R8]
    @(posedge clk_sys_i)
    !rstn_i |=>
      iso_w == pport_pkg::ISO_RST)
    else $error("stored isolation not reset");

  a_rst_lk: assert property ( // [R8]
    @(posedge clk_sys_i)
    !rstn_i |=>
      !st_r.lk_seen && !st_r.wr_seen)
    else $error("capture not cleared by reset");

endmodule : pport_fwd_mask

// *** pkg/pport_pkg.sv ***
// Package for protected port forward mask: widths, reset values, carriers
// How it works
// [R1] Frames from an isolated port reach only promiscuous ports of the VLAN.
// [R2] An isolated port receives frames only when they entered on a promiscuous port.
// [R3] Frames from a promiscuous port may go to any member port.
// [R4] A promiscuous port accepts frames from every member port.
// [R5] Promiscuous ingress uses the VLAN member mask unchanged.
// [R6] Isolated ingress ANDs the VLAN mask with the promiscuous-port mask.
// [R7] One isolation setting per port, shared by all private VLANs.
// [R8] After reset every port is promiscuous.
// [R9] Isolation only narrows the VLAN mask, never widens it.
// [R10] Management reads back isolated and promiscuous port sets.
// [R11] One bit per port, 1 means isolated; writes affect later lookups.
package pport_pkg;
  localparam int unsigned NPORTS   = 24;
  localparam int unsigned PIDX_W   = 5;
  localparam logic [23:0] ISO_RST  = 24'h00_0000;
  localparam logic [23:0] ALL_PORT = 24'hFF_FFFF;

  typedef logic [NPORTS-1:0] pmask_t;

  typedef struct packed {
    logic                valid;
    logic [PIDX_W-1:0]   src_port;
    pmask_t              vlan_mask;
  } lookup_s;

  typedef struct packed {
    logic   valid;
    pmask_t fwd_mask;
  } result_s;

  typedef struct packed {
    logic   wr;
    pmask_t wr_mask;
    pmask_t wr_data;
  } cfg_s;
endpackage : pport_pkg

// *** logic/pport_iso_store.sv ***
// Isolation bit store, one bit per port, registered readback
`timescale 1ns/100ps
module pport_iso_store (
  input  wire logic              clk_sys_i,
  input  wire logic              rstn_i,
  input  wire pport_pkg::cfg_s   cfg_i,
  output logic [pport_pkg::NPORTS-1:0] iso_o
);
  typedef struct packed {
    logic [pport_pkg::NPORTS-1:0] iso;
  } st_s;
  st_s st_r;
  st_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (cfg_i.wr) begin
      // Masked write so single ports change alone
      st_nxt.iso = (st_r.iso & ~cfg_i.wr_mask) | (cfg_i.wr_data & cfg_i.wr_mask); // [R11]
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      st_r.iso <= pport_pkg::ISO_RST; // [R8]
    end else begin
      st_r <= st_nxt;
    end
  end

  assign iso_o = st_r.iso;

  a_iso_reset: assert property (@(posedge clk_sys_i) !rstn_i |=> iso_o == '0) // [R8]
    else $error("isolation set not cleared by reset");
  a_iso_write: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    cfg_i.wr |=> ((iso_o & $past(cfg_i.wr_mask)) == ($past(cfg_i.wr_data) & $past(cfg_i.wr_mask)))) // [R11]
    else $error("isolation write not applied");
endmodule : pport_iso_store

// *** bench/vlan_src_model.sv ***
// Forwarding lookup model that feeds VLAN member masks
`timescale 1ns/100ps
module vlan_src_model (
  input  wire logic         clk_sys_i,
  output pport_pkg::lookup_s lookup_o
);
  initial lookup_o = '0;
  task automatic issue(input logic [4:0] src, input pport_pkg::pmask_t vm);
    @(negedge clk_sys_i);
    lookup_o <= '{1'b1, src, vm};
  endtask : issue
  task automatic idle();
    @(negedge clk_sys_i);
    // Released lines flip so stale values cannot pass as held data
    lookup_o <= '{1'b0, ~lookup_o.src_port, ~lookup_o.vlan_mask};
  endtask : idle
endmodule : vlan_src_model

// *** bench/protected_port_forward_mask_test.sv ***
// Bench for protected port forward mask
`timescale 1ns/100ps
module protected_port_forward_mask_test;
  logic               clk_sys_i = 0;
  logic               rstn_i = 0;
  pport_pkg::lookup_s lookup_i;
  pport_pkg::cfg_s    cfg_i = '0;
  pport_pkg::result_s result_o;
  pport_pkg::pmask_t  iso_ports_o, prom_ports_o, iso_m = '0, rv = 24'h00_2DAF, exp_q[$];
  int                 fail_count = 0, num_checks = 0, cyc = 0;
  initial forever #5 clk_sys_i = ~clk_sys_i;
  vlan_src_model p_u (.clk_sys_i(clk_sys_i), .lookup_o(lookup_i));
  pport_fwd_mask dut_u (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .lookup_i(lookup_i),
    .cfg_i(cfg_i), .result_o(result_o), .iso_ports_o(iso_ports_o), .prom_ports_o(prom_ports_o));
  function automatic pport_pkg::pmask_t lfsr(input pport_pkg::pmask_t s);
    return {s[22:0], s[23] ^ s[22] ^ s[21] ^ s[16]};
  endfunction : lfsr
  task automatic chk(input string n, input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic tally_and_finish();
    if (fail_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic look(input logic [4:0] s);
    rv = lfsr(rv);
    // Ports 24 and up count as promiscuous
    exp_q.push_back((s < 24 && iso_m[s]) ? rv & ~iso_m : rv);
    p_u.issue(s, rv);
  endtask : look
  task automatic cfg(input pport_pkg::pmask_t m, input pport_pkg::pmask_t d);
    @(negedge clk_sys_i);
    cfg_i <= '{1'b1, m, d};
    iso_m = (iso_m & ~m) | (d & m);
    @(negedge clk_sys_i);
    cfg_i <= '{1'b0, ~m, ~d};
    repeat (2) @(negedge clk_sys_i);
    chk("iso_ports", iso_ports_o, iso_m);
    chk("prom_ports", prom_ports_o, ~iso_m);
  endtask : cfg
  always @(negedge clk_sys_i) begin
    cyc++;
    if (cyc > 3000) begin
      fail_count++;
      tally_and_finish();
    end
    if (result_o.valid === 1'b1) begin
      chk("fwd_mask", result_o.fwd_mask, exp_q.size() ? exp_q.pop_front() : 'x);
    end
  end
  initial begin
    repeat (6) @(negedge clk_sys_i);
    rstn_i <= 1'b1;
    chk("iso_ports", iso_ports_o, pport_pkg::ISO_RST);
    chk("prom_ports", prom_ports_o, pport_pkg::ALL_PORT);
    for (int k = 0; k < 7; k++) begin
      // First pass runs all-promiscuous; later passes mix masked writes
      if (k > 0) cfg(lfsr(rv) | (k == 6 ? '1 : '0), rv);
      for (int i = 0; i < 32; i++) look(i[4:0]);
      p_u.idle();
    end
    repeat (3) @(negedge clk_sys_i);
    chk("pending", 24'(exp_q.size()), 24'h00_0000);
    tally_and_finish();
  end
endmodule : protected_port_forward_mask_test
